// >>> inc/ubm_cfg.svh
// Constants of the bus cycle break matcher: register offsets, field
// positions, reset values and trigger pulse widths.
// Assumes a 32-bit APB with byte addresses on paddr[7:0].
`ifndef UBM_CFG_SVH
`define UBM_CFG_SVH

// Register byte offsets
`define UBM_OFF_ADDR_HI   8'h00
`define UBM_OFF_ADDR_LO   8'h04
`define UBM_OFF_IGN_HI    8'h08
`define UBM_OFF_IGN_LO    8'h0C
`define UBM_OFF_CYC_SEL   8'h10
`define UBM_OFF_OUT_CTRL  8'h14
`define UBM_OFF_STATUS    8'h18

// Writable masks and reset values
`define UBM_CYC_SEL_MASK  16'h00FF
`define UBM_OUT_CTRL_MASK 16'h0007
`define UBM_RESET_VALUE   16'h0000

// Field positions in the cycle select register
`define UBM_SRC_LSB       6
`define UBM_KIND_LSB      4
`define UBM_DIR_LSB       2
`define UBM_SIZE_LSB      0
// Field positions in the output control register
`define UBM_PW_LSB        1
`define UBM_INHIBIT_BIT   0

// Operand size codes seen on the bus monitor
`define UBM_SIZE_WORD     2'h2

// Trigger low time in phi cycles
`define UBM_PW_DIV1       5'h01
`define UBM_PW_DIV4       5'h04
`define UBM_PW_DIV8       5'h08
`define UBM_PW_DIV16      5'h10

`endif

// >>> inc/ubm_pkg.sv
// Types shared by the bus cycle break matcher modules.
// Constants live in ubm_cfg.svh.
package ubm_pkg;

  typedef enum logic {
    UBM_PULSE_IDLE,
    UBM_PULSE_LOW
  } ubm_pulse_st_t;

  typedef struct packed {
    ubm_pulse_st_t st;
    logic [4:0]    remain;
    logic          trig_n;
  } ubm_pulse_t;

  typedef struct packed {
    logic [15:0] addr_hi;
    logic [15:0] addr_lo;
    logic [15:0] ign_hi;
    logic [15:0] ign_lo;
    logic [15:0] cyc_sel;
    logic [15:0] out_ctrl;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq_req;
    logic        hit_second;
    logic        trig_start;
  } ubm_state_t;

endpackage

// >>> logic/ubm_match.sv
// Combinational break condition judge for one observed bus cycle.
// Assumes the bus monitor inputs are stable while cyc_valid is high.
`timescale 1ns/1ps
`include "ubm_cfg.svh"
module ubm_match (
  input  wire logic [31:0] cmp_addr,
  input  wire logic [31:0] ign_bits,
  input  wire logic [7:0]  cyc_sel,
  input  wire logic        cyc_valid,
  input  wire logic        cyc_dma,
  input  wire logic        cyc_fetch,
  input  wire logic        cyc_write,
  input  wire logic [1:0]  cyc_size,
  input  wire logic [31:0] cyc_addr,
  input  wire logic        cyc_dual_fetch,
  output logic             hit_first,
  output logic             hit_second
);

  // A two-bit select enables the low or the high alternative; 00 enables none
  function automatic logic sel_hit(input logic [1:0] sel, input logic lo_alt,
                                   input logic hi_alt);
    sel_hit = (sel[0] & lo_alt) | (sel[1] & hi_alt);
  endfunction

  logic [1:0]  src_sel;
  logic [1:0]  kind_sel;
  logic [1:0]  dir_sel;
  logic [1:0]  size_sel;
  logic [1:0]  eff_size;
  logic        attr_ok;
  logic [31:0] second_addr;

  assign src_sel  = cyc_sel[`UBM_SRC_LSB+1:`UBM_SRC_LSB];
  assign kind_sel = cyc_sel[`UBM_KIND_LSB+1:`UBM_KIND_LSB];
  assign dir_sel  = cyc_sel[`UBM_DIR_LSB+1:`UBM_DIR_LSB];
  assign size_sel = cyc_sel[`UBM_SIZE_LSB+1:`UBM_SIZE_LSB];

  // Fetches are word size even when two arrive in one cycle
  assign eff_size = cyc_fetch ? `UBM_SIZE_WORD : cyc_size;

  // Zero in any of the three select groups leaves attr_ok low
  assign attr_ok = cyc_valid
                 & sel_hit(src_sel, ~cyc_dma, cyc_dma)
                 & sel_hit(kind_sel, cyc_fetch, ~cyc_fetch)
                 & sel_hit(dir_sel, ~cyc_write, cyc_write)
                 & ((size_sel == 2'h0) | (size_sel == eff_size));

  // Second instruction of a 32-bit fetch starts two bytes on
  assign second_addr = {cyc_addr[31:2], 2'h2};

  assign hit_first  = attr_ok & (((cyc_addr ^ cmp_addr) & ~ign_bits) == 32'h0);
  assign hit_second = attr_ok & cyc_fetch & cyc_dual_fetch
                    & (((second_addr ^ cmp_addr) & ~ign_bits) == 32'h0);
endmodule

// >>> logic/ubm_pulse.sv
// Active-low trigger pulse generator with a selectable low time.
// Assumes start is a one-cycle pulse; a new start restarts the pulse.
`timescale 1ns/1ps
`include "ubm_cfg.svh"
module ubm_pulse (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       clr,
  input  wire logic       start,
  input  wire logic [1:0] width_sel,
  output logic            trig_n
);

  ubm_pkg::ubm_pulse_t s_reg;
  ubm_pkg::ubm_pulse_t s_next;
  logic [4:0]          width;

  // Low time in phi cycles for each select code
  always_comb begin
    case (width_sel)
      2'h0:    width = `UBM_PW_DIV1;
      2'h1:    width = `UBM_PW_DIV4;
      2'h2:    width = `UBM_PW_DIV8;
      default: width = `UBM_PW_DIV16;
    endcase
  end

  // Counting down the low time; remain holds cycles still to go
  always_comb begin
    s_next = s_reg;
    if (clr) begin
      s_next.st     = ubm_pkg::UBM_PULSE_IDLE;
      s_next.remain = 5'h00;
      s_next.trig_n = 1'b1;
    end else if (start) begin
      s_next.st     = ubm_pkg::UBM_PULSE_LOW;
      s_next.remain = width - 5'h01;
      s_next.trig_n = 1'b0;
    end else begin
      case (s_reg.st)
        ubm_pkg::UBM_PULSE_IDLE: begin
          s_next.trig_n = 1'b1;
        end
        ubm_pkg::UBM_PULSE_LOW: begin
          if (s_reg.remain == 5'h00) begin
            s_next.st     = ubm_pkg::UBM_PULSE_IDLE;
            s_next.trig_n = 1'b1;
          end else begin
            s_next.remain = s_reg.remain - 5'h01;
          end
        end
        default: begin
          s_next.st     = ubm_pkg::UBM_PULSE_IDLE;
          s_next.trig_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg.st     <= ubm_pkg::UBM_PULSE_IDLE;
      s_reg.remain <= 5'h00;
      s_reg.trig_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign trig_n = s_reg.trig_n;
endmodule

// >>> logic/ubm_top.sv
// Bus cycle break matcher: APB register file, break judge, pending
// interrupt request and trigger output.
// Assumes the bus monitor inputs are synchronous to clk and that the
// interrupt controller pulses irq_ack when it takes the request.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "ubm_cfg.svh"
module ubm_top (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        module_standby,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cyc_valid,
  input  wire logic        cyc_dma,
  input  wire logic        cyc_fetch,
  input  wire logic        cyc_write,
  input  wire logic [1:0]  cyc_size,
  input  wire logic [31:0] cyc_addr,
  input  wire logic        cyc_dual_fetch,
  input  wire logic        irq_ack,
  output logic             irq_req,
  output logic             break_on_second,
  output logic             match_trigger_out_n
);

  ubm_pkg::ubm_state_t s_reg;
  ubm_pkg::ubm_state_t s_next;

  logic        hit_first;
  logic        hit_second;
  logic        hit_any;
  logic        setup_phase;
  logic        access_phase;
  logic        do_write;
  logic        addr_known;
  logic [15:0] wr_half;
  logic [31:0] rd_word;

  // Merge a written halfword into its register under the byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wdat,
                                          input logic [1:0]  strb,
                                          input logic [15:0] wmask);
    logic [15:0] lane;
    lane   = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge16 = (old & ~lane) | (wdat & lane);
  endfunction

  // Offset decode, used for the error answer, which also blocks the write
  function automatic logic known_offset(input logic [7:0] a);
    case (a)
      `UBM_OFF_ADDR_HI,
      `UBM_OFF_ADDR_LO,
      `UBM_OFF_IGN_HI,
      `UBM_OFF_IGN_LO,
      `UBM_OFF_CYC_SEL,
      `UBM_OFF_OUT_CTRL,
      `UBM_OFF_STATUS:  known_offset = 1'b1;
      default:          known_offset = 1'b0;
    endcase
  endfunction

  // Break judge on the current bus cycle, against live settings
  ubm_match u_match (
    .cmp_addr       ({s_reg.addr_hi, s_reg.addr_lo}),
    .ign_bits       ({s_reg.ign_hi, s_reg.ign_lo}),
    .cyc_sel        (s_reg.cyc_sel[7:0]),
    .cyc_valid      (cyc_valid),
    .cyc_dma        (cyc_dma),
    .cyc_fetch      (cyc_fetch),
    .cyc_write      (cyc_write),
    .cyc_size       (cyc_size),
    .cyc_addr       (cyc_addr),
    .cyc_dual_fetch (cyc_dual_fetch),
    .hit_first      (hit_first),
    .hit_second     (hit_second)
  );

  assign hit_any = hit_first | hit_second;

  // Trigger pulse starts one edge after the edge that raises the request
  ubm_pulse u_pulse (
    .clk       (clk),
    .resetn    (resetn),
    .clr       (module_standby),
    .start     (s_reg.trig_start),
    .width_sel (s_reg.out_ctrl[`UBM_PW_LSB+1:`UBM_PW_LSB]),
    .trig_n    (match_trigger_out_n)
  );

  // APB phases; a write lands only on the access edge with pready high
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable & s_reg.pready;
  assign do_write     = access_phase & pwrite & ~s_reg.pslverr;
  assign addr_known   = known_offset(paddr);
  assign wr_half      = pwdata[15:0];

  // Read mux; reserved bits are stored as zero so they read zero
  always_comb begin
    case (paddr)
      `UBM_OFF_ADDR_HI:  rd_word = {16'h0000, s_reg.addr_hi};
      `UBM_OFF_ADDR_LO:  rd_word = {16'h0000, s_reg.addr_lo};
      `UBM_OFF_IGN_HI:   rd_word = {16'h0000, s_reg.ign_hi};
      `UBM_OFF_IGN_LO:   rd_word = {16'h0000, s_reg.ign_lo};
      `UBM_OFF_CYC_SEL:  rd_word = {16'h0000, s_reg.cyc_sel};
      `UBM_OFF_OUT_CTRL: rd_word = {16'h0000, s_reg.out_ctrl};
      `UBM_OFF_STATUS:   rd_word = {30'h0, s_reg.hit_second, s_reg.irq_req};
      default:           rd_word = 32'h00000000;
    endcase
  end

  // Whole next state of the block
  always_comb begin
    s_next = s_reg;

    // Zero-wait slave: answer is armed in setup, given in access
    s_next.pready  = 1'b0;
    s_next.pslverr = 1'b0;
    if (setup_phase) begin
      s_next.pready  = 1'b1;
      s_next.pslverr = ~addr_known;
      s_next.prdata  = pwrite ? 32'h00000000 : rd_word;
    end

    if (do_write) begin
      case (paddr)
        `UBM_OFF_ADDR_HI: begin
          s_next.addr_hi = merge16(s_reg.addr_hi, wr_half, pstrb[1:0], 16'hFFFF);
        end
        `UBM_OFF_ADDR_LO: begin
          s_next.addr_lo = merge16(s_reg.addr_lo, wr_half, pstrb[1:0], 16'hFFFF);
        end
        `UBM_OFF_IGN_HI: begin
          s_next.ign_hi = merge16(s_reg.ign_hi, wr_half, pstrb[1:0], 16'hFFFF);
        end
        `UBM_OFF_IGN_LO: begin
          s_next.ign_lo = merge16(s_reg.ign_lo, wr_half, pstrb[1:0], 16'hFFFF);
        end
        `UBM_OFF_CYC_SEL: begin
          // Reserved bits 15:8 cannot be set
          s_next.cyc_sel = merge16(s_reg.cyc_sel, wr_half, pstrb[1:0],
                                   `UBM_CYC_SEL_MASK);
        end
        `UBM_OFF_OUT_CTRL: begin
          // Reserved bits 15:3 cannot be set
          s_next.out_ctrl = merge16(s_reg.out_ctrl, wr_half, pstrb[1:0],
                                    `UBM_OUT_CTRL_MASK);
        end
        default: begin
          s_next.addr_hi = s_reg.addr_hi;
        end
      endcase
    end

    // A match fires the trigger unless module standby is high; the inhibit bit gates only the request
    s_next.trig_start = hit_any;
    if (hit_any) begin
      s_next.hit_second = hit_second & ~hit_first;
    end

    // Request stays pending until taken; a new match beats the ack unless the inhibit bit is set
    if (hit_any & ~s_reg.out_ctrl[`UBM_INHIBIT_BIT]) begin
      s_next.irq_req = 1'b1;
    end else if (irq_ack) begin
      s_next.irq_req = 1'b0;
    end

    // Module standby wipes settings and pending state like power-on
    if (module_standby) begin
      s_next.addr_hi    = `UBM_RESET_VALUE;
      s_next.addr_lo    = `UBM_RESET_VALUE;
      s_next.ign_hi     = `UBM_RESET_VALUE;
      s_next.ign_lo     = `UBM_RESET_VALUE;
      s_next.cyc_sel    = `UBM_RESET_VALUE;
      s_next.out_ctrl   = `UBM_RESET_VALUE;
      s_next.irq_req    = 1'b0;
      s_next.hit_second = 1'b0;
      s_next.trig_start = 1'b0;
    end
  end

  // Power-on reset; software standby has no input so contents survive it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg.addr_hi    <= `UBM_RESET_VALUE;
      s_reg.addr_lo    <= `UBM_RESET_VALUE;
      s_reg.ign_hi     <= `UBM_RESET_VALUE;
      s_reg.ign_lo     <= `UBM_RESET_VALUE;
      s_reg.cyc_sel    <= `UBM_RESET_VALUE;
      s_reg.out_ctrl   <= `UBM_RESET_VALUE;
      s_reg.prdata     <= 32'h00000000;
      s_reg.pready     <= 1'b0;
      s_reg.pslverr    <= 1'b0;
      s_reg.irq_req    <= 1'b0;
      s_reg.hit_second <= 1'b0;
      s_reg.trig_start <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata          = s_reg.prdata;
  assign pready          = s_reg.pready;
  assign pslverr         = s_reg.pslverr;
  assign irq_req         = s_reg.irq_req;
  assign break_on_second = s_reg.hit_second;
endmodule

// >>> sim/ubm_properties.sv
// Port checker of the break matcher: bus answer, request and trigger timing.
// Assumes a bind to ubm_top; one clock domain, reset active low.
`timescale 1ns/1ps
module ubm_properties (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        module_standby,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cyc_valid,
  input wire logic        irq_ack,
  input wire logic        irq_req,
  input wire logic        match_trigger_out_n
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!resetn);

  // Bus answer: zero wait states, one cycle wide, upper half always zero
  property p_ready_next; psel && !penable |=> pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("no answer after setup");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("answer too long");
  property p_upper_zero; pready |-> prdata[31:16] == 16'h0000; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper half not zero");
  property p_err_zero; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read not zero");

  // A request and a trigger pulse always trace back to an observed cycle
  property p_irq_cause; $rose(irq_req) |-> $past(cyc_valid); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("request without cycle");
  property p_trig_with; $rose(irq_req) && !module_standby |=> !match_trigger_out_n; endproperty
  a_trig_with: assert property (p_trig_with) else $error("trigger not with request");
  property p_trig_cause; $fell(match_trigger_out_n) |-> $past(cyc_valid, 2); endproperty
  a_trig_cause: assert property (p_trig_cause) else $error("trigger without cycle");

  // Pending request holds until taken; standby clears the request and the trigger
  property p_irq_hold; irq_req && !irq_ack && !module_standby |=> irq_req; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("request dropped untaken");
  property p_irq_clear;
    irq_req && irq_ack && !cyc_valid && !module_standby |=> !irq_req;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("request kept after ack");
  property p_standby; module_standby |=> match_trigger_out_n && !irq_req; endproperty
  a_standby: assert property (p_standby) else $error("standby did not clear");
endmodule

// >>> sim/ubm_bus_model.sv
// Behavioural far side: CPU and DMA bus cycle source plus interrupt controller.
// Assumes the bench calls bus_cycle just after a rising edge.
`timescale 1ns/1ps
module ubm_bus_model (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        irq_req,
  output logic            cyc_valid,
  output logic            cyc_dma,
  output logic            cyc_fetch,
  output logic            cyc_write,
  output logic [1:0]      cyc_size,
  output logic [31:0]     cyc_addr,
  output logic            cyc_dual_fetch,
  output logic            irq_ack
);
  logic [3:0]  mask_level;
  logic        after_slot;
  logic        last_fetch_kind;
  logic [31:0] last_fetch;
  logic [31:0] saved_pc;

  // Start masked at level 15 so requests pend until the bench lowers it
  initial begin
    mask_level = 4'hF;
    after_slot = 1'b0;
    {cyc_valid, cyc_dma, cyc_fetch, cyc_write, cyc_size, cyc_addr, cyc_dual_fetch} = '0;
  end

  // Request has level 15: taken only at mask level 14 or lower, else held
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) irq_ack <= 1'b0;
    else irq_ack <= irq_req && !irq_ack && (mask_level < 4'hF);
  end

  // Processor side of an accepted break: the return address it would save
  always_ff @(posedge clk) begin
    if (cyc_valid) begin
      last_fetch_kind <= cyc_fetch;
      if (cyc_fetch) last_fetch <= cyc_addr;
    end
    if (irq_ack) begin
      if (last_fetch_kind && !after_slot) saved_pc <= last_fetch;
      else if (last_fetch_kind) saved_pc <= last_fetch + 32'h2;
      else saved_pc <= last_fetch + 32'h2;
    end
  end

  // One cycle valid; address inverted afterwards so a stale value never matches
  task automatic bus_cycle(input logic dma, input logic fetch, input logic wr,
                           input logic [1:0] sz, input logic [31:0] a, input logic dual);
    @(posedge clk);
    {cyc_valid, cyc_dma, cyc_fetch, cyc_write, cyc_size, cyc_addr, cyc_dual_fetch} <=
      {1'b1, dma, fetch, wr, sz, a, dual};
    @(posedge clk);
    {cyc_valid, cyc_addr} <= {1'b0, ~a};
  endtask
endmodule

// >>> sim/test_bus_cycle_break_matcher.sv
// Self-checking bench of the break matcher: registers, match table, ignore
// bits, dual fetch, pending request, standby, trigger width and inhibit.
// Assumes ubm_top, ubm_bus_model and ubm_properties are compiled before.
`timescale 1ns/1ps
module test_bus_cycle_break_matcher;
  logic        clk, resetn, module_standby, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, cyc_addr;
  logic [3:0]  pstrb;
  logic        cyc_valid, cyc_dma, cyc_fetch, cyc_write, cyc_dual_fetch;
  logic [1:0]  cyc_size;
  logic        irq_ack, irq_req, break_on_second, trig_n;
  int          err_count = 0;
  int          comparisons = 0;
  // Code byte: dma, fetch, write, expected, dual, 0, size; high byte is the select value
  localparam logic [15:0] CASES [20] = '{16'h6A32, 16'h6A21, 16'h6A02, 16'h6AA2,
    16'hAAB2, 16'hEAB2, 16'hEA32, 16'h5453, 16'h5651, 16'h6411, 16'h6713, 16'h6702,
    16'h6511, 16'h5402, 16'h7412, 16'h6E32, 16'h6E12, 16'h2A22, 16'h4A22, 16'h6222};
  localparam logic [31:0] WIDTHS [4] = '{32'h1, 32'h4, 32'h8, 32'h10};

  ubm_top ubm_top_inst (.clk(clk), .resetn(resetn), .module_standby(module_standby),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cyc_valid(cyc_valid), .cyc_dma(cyc_dma), .cyc_fetch(cyc_fetch),
    .cyc_write(cyc_write), .cyc_size(cyc_size), .cyc_addr(cyc_addr),
    .cyc_dual_fetch(cyc_dual_fetch), .irq_ack(irq_ack), .irq_req(irq_req),
    .break_on_second(break_on_second), .match_trigger_out_n(trig_n));
  ubm_bus_model ubm_bus_model_inst (.clk(clk), .resetn(resetn), .irq_req(irq_req),
    .cyc_valid(cyc_valid), .cyc_dma(cyc_dma), .cyc_fetch(cyc_fetch),
    .cyc_write(cyc_write), .cyc_size(cyc_size), .cyc_addr(cyc_addr),
    .cyc_dual_fetch(cyc_dual_fetch), .irq_ack(irq_ack));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic expire();
    err_count++;
    $display("Error wait expected done seen timeout");
    report_and_stop();
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // APB transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'h2, wr, a, d, 4'hF};
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) expire();
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk("prdata", exp, rd);
    chk("pslverr", 32'(experr), 32'(err));
  endtask
  // Request seen one cycle after the bus cycle, trigger low one cycle later
  task automatic hit(input logic [7:0] c, input logic [31:0] a, input logic ei, input logic et);
    ubm_bus_model_inst.bus_cycle(c[7], c[6], c[5], c[1:0], a, c[3]);
    #1;
    chk("irq_req", 32'(ei), 32'(irq_req));
    @(posedge clk);
    #1;
    chk("trigger", 32'(!et), 32'(trig_n));
  endtask
  task automatic settle();
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (irq_req === 1'b0 && trig_n === 1'b1) break;
    end
    if (n == 40) expire();
  endtask

  task automatic t_regs();
    for (int i = 0; i < 7; i++) rchk(8'(i * 4), 32'h0, 1'b0);
    rchk(8'h1C, 32'h0, 1'b1);
    wreg(8'h10, 32'hFFFF_FFFF);
    rchk(8'h10, 32'h00FF, 1'b0);
    wreg(8'h14, 32'hFFFF_FFFF);
    rchk(8'h14, 32'h0007, 1'b0);
    wreg(8'h00, 32'hFFFF_A5C3);
    rchk(8'h00, 32'hA5C3, 1'b0);
    wreg(8'h14, 32'h0);
    $display("t_regs done");
  endtask
  // Every select code of every field, against matching and missing attributes
  task automatic t_table();
    wreg(8'h00, 32'h0012);
    wreg(8'h04, 32'h3456);
    ubm_bus_model_inst.mask_level = 4'h0;
    for (int i = 0; i < 20; i++) begin
      wreg(8'h10, 32'(CASES[i][15:8]));
      hit(CASES[i][7:0], 32'h0012_3456, CASES[i][4], CASES[i][4]);
      settle();
    end
    $display("t_table done");
  endtask
  task automatic t_mask();
    wreg(8'h10, 32'h006A);
    wreg(8'h0C, 32'h00FF);
    hit(8'h22, 32'h0012_34AB, 1'b1, 1'b1);
    settle();
    hit(8'h22, 32'h0012_3556, 1'b0, 1'b0);
    settle();
    wreg(8'h08, 32'hFFFF);
    hit(8'h22, 32'hABCD_3456, 1'b1, 1'b1);
    settle();
    wreg(8'h08, 32'h0);
    wreg(8'h0C, 32'h0);
    $display("t_mask done");
  endtask
  task automatic t_dual();
    wreg(8'h10, 32'h0056);
    wreg(8'h00, 32'h0);
    wreg(8'h04, 32'h0406);
    hit(8'h4A, 32'h0000_0404, 1'b1, 1'b1);
    chk("second", 32'h1, 32'(break_on_second));
    settle();
    hit(8'h42, 32'h0000_0404, 1'b0, 1'b0);
    settle();
    wreg(8'h04, 32'h0404);
    hit(8'h4A, 32'h0000_0404, 1'b1, 1'b1);
    chk("second", 32'h0, 32'(break_on_second));
    settle();
    chk("saved pc", 32'h0000_0404, ubm_bus_model_inst.saved_pc);
    $display("t_dual done");
  endtask
  // Held at mask level 15, taken once the level drops to 14
  task automatic t_pending();
    ubm_bus_model_inst.mask_level = 4'hF;
    hit(8'h42, 32'h0000_0404, 1'b1, 1'b1);
    repeat (6) @(posedge clk);
    chk("irq_req held", 32'h1, 32'(irq_req));
    rchk(8'h18, 32'h1, 1'b0);
    ubm_bus_model_inst.after_slot = 1'b1;
    ubm_bus_model_inst.mask_level = 4'hE;
    settle();
    chk("saved pc", 32'h0000_0406, ubm_bus_model_inst.saved_pc);
    ubm_bus_model_inst.after_slot = 1'b0;
    ubm_bus_model_inst.mask_level = 4'hF;
    hit(8'h42, 32'h0000_0404, 1'b1, 1'b1);
    @(posedge clk);
    module_standby <= 1'b1;
    @(posedge clk);
    module_standby <= 1'b0;
    #1;
    chk("irq_req", 32'h0, 32'(irq_req));
    for (int i = 0; i < 7; i++) rchk(8'(i * 4), 32'h0, 1'b0);
    $display("t_pending done");
  endtask
  task automatic t_width();
    int n;
    ubm_bus_model_inst.mask_level = 4'h0;
    wreg(8'h00, 32'h0012);
    wreg(8'h04, 32'h3456);
    wreg(8'h10, 32'h006A);
    for (int w = 0; w < 4; w++) begin
      wreg(8'h14, 32'(w * 2));
      hit(8'h22, 32'h0012_3456, 1'b1, 1'b1);
      for (n = 1; n < 40; n++) begin
        @(posedge clk);
        #1;
        if (trig_n !== 1'b0) break;
      end
      chk("pulse width", WIDTHS[w], 32'(n));
      settle();
    end
    chk("saved pc", 32'h0000_0406, ubm_bus_model_inst.saved_pc);
    wreg(8'h14, 32'h1);
    hit(8'h22, 32'h0012_3456, 1'b0, 1'b1);
    settle();
    $display("t_width done");
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard for the whole run
  initial begin
    repeat (100000) @(posedge clk);
    expire();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, module_standby} = '0;
    resetn = 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_table();
    t_mask();
    t_dual();
    t_pending();
    t_width();
    report_and_stop();
  end
endmodule

bind ubm_top ubm_properties ubm_properties_inst (.clk(clk), .resetn(resetn),
  .module_standby(module_standby), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cyc_valid(cyc_valid), .irq_ack(irq_ack),
  .irq_req(irq_req), .match_trigger_out_n(match_trigger_out_n));
